// File: pkg/chs_defines.svh
// Constants for the charger status and power-path block
`ifndef CHS_DEFINES_SVH
`define CHS_DEFINES_SVH
// Serial port
`define CHS_BYTE_BITS    4'h8
`define CHS_ADDR_DEFAULT 7'h09
// Control sub addresses
`define CHS_SUB_LIMITS   8'h00
`define CHS_SUB_CHARGER  8'h01
`define CHS_SUB_MASK     8'h02
// Reset values
`define CHS_LIMITS_RST   8'h00
`define CHS_CHARGER_RST  8'h00
`define CHS_MASK_RST     8'h00
// Limits byte fields
`define CHS_ILIM_HI      7
`define CHS_ILIM_LO      5
`define CHS_CX_HI        1
`define CHS_CX_LO        0
`define CHS_SUSP_LOW     3'h6
`define CHS_SUSP_HIGH    3'h7
// Charger byte fields
`define CHS_DIS_BIT      4
`define CHS_VFLOAT_BIT   2
`define CHS_TREG_BIT     1
// Status field codes
`define CHS_THM_OK       2'h0
`define CHS_THM_COLD     2'h1
`define CHS_THM_HOT      2'h2
`define CHS_THM_CRIT     2'h3
`define CHS_CHG_OFF      2'h0
`define CHS_CHG_CC       2'h1
`define CHS_CHG_CV_HI    2'h2
`define CHS_CHG_CV_LO    2'h3
// Bad cell time
`define CHS_DEFECTIVE_CELL_FLAG_S    64'h708
`define CHS_CLK_HZ       64'h7735940
`define CHS_DEFECTIVE_CELL_FLAG_CYC  (`CHS_DEFECTIVE_CELL_FLAG_S * `CHS_CLK_HZ)
`define CHS_NPINS        15
`endif

// File: pkg/chs_pkg.sv
// Types for the charger status and power-path block
package chs_pkg;
	typedef enum logic [2:0] {
		CHS_IDLE  = 3'h0,
		CHS_ADDR  = 3'h1,
		CHS_ACK_A = 3'h2,
		CHS_WR    = 3'h3,
		CHS_ACK_W = 3'h4,
		CHS_RD    = 3'h5,
		CHS_ACK_R = 3'h6
	} chs_state_type;
endpackage

// File: logic/chs_status.sv
// Charger status byte, serial port and power-path enables
`timescale 1ns/100ps
`default_nettype none
`include "chs_defines.svh"

module chs_status
	import chs_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR        = `CHS_ADDR_DEFAULT,
	parameter logic [37:0] BAD_CELL_CYCLES = 38'(`CHS_DEFECTIVE_CELL_FLAG_CYC)
) (
	input  wire logic       CLK_I,
	input  wire logic       RST_N_I,
	input  wire logic       CE_I,
	input  wire logic       SCL_I,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE_O,
	input  wire logic       BUS_LOCKOUT_OK_I,
	input  wire logic       BUS_REL_LOCKOUT_OK_I,
	input  wire logic       AUX_DETECT_OK_I,
	input  wire logic       AUX_REL_OK_I,
	input  wire logic       PRECHARGE_LOW_I,
	input  wire logic       THERMAL_REG_I,
	input  wire logic       THERM_COLD_I,
	input  wire logic       THERM_HOT_I,
	input  wire logic       THERM_CRIT_I,
	input  wire logic       FLOAT_REACHED_I,
	input  wire logic       BELOW_CX_I,
	input  wire logic       INPUT_LIMIT_I,
	input  wire logic       CYCLE_DONE_I,
	output logic            BUS_REG_EN_O,
	output logic            CHARGE_EN_O,
	output logic            IDEAL_DIODE_EN_O,
	output logic [2:0]      INPUT_LIMIT_SEL_O,
	output logic [1:0]      CX_SEL_O,
	output logic            FLOAT_HIGH_O,
	output logic            TREG_LOW_O,
	output logic            IRQ_PENDING_O
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [`CHS_NPINS-1:0] pin_raw;
	logic [`CHS_NPINS-1:0] pin_s;

	assign pin_raw = {SCL_I, SDA_I, BUS_LOCKOUT_OK_I, BUS_REL_LOCKOUT_OK_I,
		AUX_DETECT_OK_I, AUX_REL_OK_I, PRECHARGE_LOW_I, THERMAL_REG_I,
		THERM_COLD_I, THERM_HOT_I, THERM_CRIT_I, FLOAT_REACHED_I,
		BELOW_CX_I, INPUT_LIMIT_I, CYCLE_DONE_I};

	genvar gi;
	generate
		for (gi = 0; gi < `CHS_NPINS; gi++) begin : g_sync
			logic f1_r;
			logic f2_r;
			logic f3_r;
			logic val_r;
			always_ff @(posedge CLK_I) begin
				if (!RST_N_I) begin
					f1_r  <= 1'b0;
					f2_r  <= 1'b0;
					f3_r  <= 1'b0;
					val_r <= 1'b0;
				end else if (CE_I) begin
					f1_r <= pin_raw[gi];
					f2_r <= f1_r;
					f3_r <= f2_r;
					// Change accepted only once both late stages agree
					if (f2_r == f3_r) begin
						val_r <= f3_r;
					end
				end
			end
			assign pin_s[gi] = val_r;
		end
	endgenerate

	logic scl_s;
	logic sda_s;
	logic bus_lock_s;
	logic bus_rel_s;
	logic aux_det_s;
	logic aux_rel_s;
	logic pre_low_s;
	logic treg_s;
	logic cold_s;
	logic hot_s;
	logic crit_s;
	logic cv_s;
	logic below_cx_s;
	logic ilim_s;
	logic done_s;

	assign {scl_s, sda_s, bus_lock_s, bus_rel_s, aux_det_s, aux_rel_s,
		pre_low_s, treg_s, cold_s, hot_s, crit_s, cv_s, below_cx_s,
		ilim_s, done_s} = pin_s;

	// ----------------------------------------
	// Control bytes
	// ----------------------------------------
	logic [7:0] limits_r;
	logic [7:0] charger_r;
	logic [7:0] mask_r;
	logic [7:0] sub_r;
	logic [7:0] sh_r;
	logic       wr_stb;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			limits_r  <= `CHS_LIMITS_RST;
			charger_r <= `CHS_CHARGER_RST;
			mask_r    <= `CHS_MASK_RST;
		end else if (CE_I && wr_stb) begin
			// Other sub addresses, the status byte among them, are dropped
			unique case (sub_r)
				`CHS_SUB_LIMITS:  limits_r  <= sh_r;
				`CHS_SUB_CHARGER: charger_r <= sh_r;
				`CHS_SUB_MASK:    mask_r    <= sh_r;
				default: ;
			endcase
		end
	end

	logic [2:0] ilim_sel;
	logic       suspend;
	logic       disable_cmd;

	assign ilim_sel    = limits_r[`CHS_ILIM_HI:`CHS_ILIM_LO];
	assign suspend     = (ilim_sel == `CHS_SUSP_LOW) || (ilim_sel == `CHS_SUSP_HIGH);
	assign disable_cmd = charger_r[`CHS_DIS_BIT];

	assign INPUT_LIMIT_SEL_O = ilim_sel;
	assign CX_SEL_O          = limits_r[`CHS_CX_HI:`CHS_CX_LO];
	assign FLOAT_HIGH_O      = charger_r[`CHS_VFLOAT_BIT];
	assign TREG_LOW_O        = charger_r[`CHS_TREG_BIT];

	// ----------------------------------------
	// Power path
	// ----------------------------------------
	logic bus_good;
	logic aux_good;
	logic power;

	assign bus_good = bus_lock_s & bus_rel_s;
	assign aux_good = aux_det_s & aux_rel_s;
	assign power    = bus_good | aux_good;
	assign BUS_REG_EN_O     = bus_good & ~suspend & ~aux_good;
	assign IDEAL_DIODE_EN_O = 1'b1;

	// ----------------------------------------
	// Charger cycle
	// ----------------------------------------
	logic power_q_r;
	logic dis_q_r;
	logic active_r;
	logic start;
	logic paused;
	logic running;

	assign start   = power & (~power_q_r | (dis_q_r & ~disable_cmd));
	assign paused  = cold_s | hot_s;
	assign running = active_r & power & ~paused;
	assign CHARGE_EN_O = running;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			power_q_r <= 1'b0;
			dis_q_r   <= 1'b0;
			active_r  <= 1'b0;
		end else if (CE_I) begin
			power_q_r <= power;
			dis_q_r   <= disable_cmd;
			if (disable_cmd) begin
				active_r <= 1'b0;
			end else if (start) begin
				active_r <= 1'b1;
			end else if (done_s) begin
				active_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Bad cell timer
	// ----------------------------------------
	logic [37:0] low_cnt_r;
	logic        bad_cell_r;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			low_cnt_r  <= 38'h0;
			bad_cell_r <= 1'b0;
		end else if (CE_I) begin
			// Dip above the threshold restarts the wait
			if (running && pre_low_s && !start) begin
				if (low_cnt_r != BAD_CELL_CYCLES) begin
					low_cnt_r <= low_cnt_r + 38'h1;
				end
			end else begin
				low_cnt_r <= 38'h0;
			end
			if (low_cnt_r == BAD_CELL_CYCLES) begin
				bad_cell_r <= 1'b1;
			end else if (start) begin
				bad_cell_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Live status byte
	// ----------------------------------------
	logic [1:0] therm_code;
	logic [1:0] chg_code;
	logic [7:0] live;

	always_comb begin
		if (crit_s) begin
			therm_code = `CHS_THM_CRIT;
		end else if (hot_s) begin
			therm_code = `CHS_THM_HOT;
		end else if (cold_s) begin
			therm_code = `CHS_THM_COLD;
		end else begin
			therm_code = `CHS_THM_OK;
		end
	end

	always_comb begin
		if (!running) begin
			chg_code = `CHS_CHG_OFF;
		end else if (!cv_s) begin
			chg_code = `CHS_CHG_CC;
		end else if (below_cx_s && !ilim_s) begin
			chg_code = `CHS_CHG_CV_LO;
		end else begin
			chg_code = `CHS_CHG_CV_HI;
		end
	end

	// Thermal flag follows whichever limit TREG_LOW_O selects
	assign live = {bus_good, aux_good, bad_cell_r, treg_s, therm_code, chg_code};

	// ----------------------------------------
	// Snapshot and pending interrupt
	// ----------------------------------------
	logic [7:0] prev_r;
	logic [7:0] snap_r;
	logic       pend_r;
	logic       rd_ack;
	logic       event_hit;

	assign event_hit     = |((live ^ prev_r) & mask_r);
	assign IRQ_PENDING_O = pend_r;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			prev_r <= 8'h00;
			snap_r <= 8'h00;
			pend_r <= 1'b0;
		end else if (CE_I) begin
			prev_r <= live;
			if (rd_ack) begin
				pend_r <= 1'b0;
				if (!pend_r) begin
					snap_r <= live;
				end
			end
			// New event wins over the clear by a read
			if (event_hit) begin
				pend_r <= 1'b1;
				snap_r <= live;
			end
		end
	end

	// ----------------------------------------
	// Serial port engine
	// ----------------------------------------
	chs_state_type st_r;
	logic       scl_q_r;
	logic       sda_q_r;
	logic [3:0] bit_r;
	logic       rw_r;
	logic       first_r;
	logic       nack_r;
	logic [7:0] tx_r;
	logic       oe_r;
	logic       rise;
	logic       fall;
	logic       start_c;
	logic       stop_c;
	logic       byte_end;
	logic       match;

	assign rise     = scl_s & ~scl_q_r;
	assign fall     = ~scl_s & scl_q_r;
	assign start_c  = scl_s & scl_q_r & sda_q_r & ~sda_s;
	assign stop_c   = scl_s & scl_q_r & ~sda_q_r & sda_s;
	assign byte_end = fall && (bit_r == `CHS_BYTE_BITS);
	assign match    = (sh_r[7:1] == DEV_ADDR);
	assign rd_ack   = (st_r == CHS_ADDR) && byte_end && match && sh_r[0];
	assign wr_stb   = (st_r == CHS_WR) && byte_end && !first_r;
	assign SDA_O    = 1'b0;
	assign SDA_OE_O = oe_r;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			st_r    <= CHS_IDLE;
			// Same level as the synchronised pins leave reset, so no false edge
			scl_q_r <= 1'b0;
			sda_q_r <= 1'b0;
			bit_r   <= 4'h0;
			sh_r    <= 8'h00;
			sub_r   <= 8'h00;
			rw_r    <= 1'b0;
			first_r <= 1'b0;
			nack_r  <= 1'b0;
			tx_r    <= 8'h00;
			oe_r    <= 1'b0;
		end else if (CE_I) begin
			scl_q_r <= scl_s;
			sda_q_r <= sda_s;
			if (start_c) begin
				st_r  <= CHS_ADDR;
				bit_r <= 4'h0;
				oe_r  <= 1'b0;
			end else if (stop_c) begin
				st_r <= CHS_IDLE;
				oe_r <= 1'b0;
			end else begin
				unique case (st_r)
					CHS_IDLE: ;
					CHS_ADDR, CHS_WR: begin
						if (rise) begin
							sh_r  <= {sh_r[6:0], sda_s};
							bit_r <= bit_r + 4'h1;
						end else if (byte_end) begin
							if (st_r == CHS_WR) begin
								oe_r    <= 1'b1;
								st_r    <= CHS_ACK_W;
								first_r <= 1'b0;
								if (first_r) begin
									sub_r <= sh_r;
								end else begin
									sub_r <= sub_r + 8'h01;
								end
							end else if (match) begin
								oe_r  <= 1'b1;
								rw_r  <= sh_r[0];
								st_r  <= CHS_ACK_A;
							end else begin
								st_r <= CHS_IDLE;
							end
						end
					end
					CHS_ACK_A: begin
						if (fall) begin
							bit_r <= 4'h0;
							if (rw_r) begin
								st_r <= CHS_RD;
								tx_r <= snap_r;
								oe_r <= ~snap_r[7];
							end else begin
								st_r    <= CHS_WR;
								first_r <= 1'b1;
								oe_r    <= 1'b0;
							end
						end
					end
					CHS_ACK_W: begin
						if (fall) begin
							oe_r  <= 1'b0;
							bit_r <= 4'h0;
							st_r  <= CHS_WR;
						end
					end
					CHS_RD: begin
						if (rise) begin
							bit_r <= bit_r + 4'h1;
						end else if (byte_end) begin
							oe_r <= 1'b0;
							st_r <= CHS_ACK_R;
						end else if (fall) begin
							tx_r <= {tx_r[6:0], 1'b0};
							oe_r <= ~tx_r[6];
						end
					end
					CHS_ACK_R: begin
						if (rise) begin
							nack_r <= sda_s;
						end else if (fall) begin
							if (nack_r) begin
								st_r <= CHS_IDLE;
							end else begin
								// Further bytes repeat the same snapshot
								st_r  <= CHS_RD;
								bit_r <= 4'h0;
								tx_r  <= snap_r;
								oe_r  <= ~snap_r[7];
							end
						end
					end
					default: st_r <= CHS_IDLE;
				endcase
			end
		end
	end

endmodule // chs_status
`default_nettype wire

// File: bench/chs_status_assertions.sv
// Checker for the charger status block
`timescale 1ns/100ps
`default_nettype none
module chs_status_checker (
	input wire logic       CLK_I,
	input wire logic       RST_N_I,
	input wire logic       CE_I,
	input wire logic       SCL_I,
	input wire logic       BUS_LOCKOUT_OK_I,
	input wire logic       AUX_DETECT_OK_I,
	input wire logic       AUX_REL_OK_I,
	input wire logic       THERM_COLD_I,
	input wire logic       THERM_HOT_I,
	input wire logic       THERM_CRIT_I,
	input wire logic       SDA_O,
	input wire logic       SDA_OE_O,
	input wire logic       BUS_REG_EN_O,
	input wire logic       CHARGE_EN_O,
	input wire logic       IDEAL_DIODE_EN_O,
	input wire logic       IRQ_PENDING_O,
	input wire logic [2:0] INPUT_LIMIT_SEL_O,
	input wire logic [1:0] CX_SEL_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I || !CE_I);
	// Seven samples cover the input synchroniser latency
	sequence s_aux_held;
		(AUX_DETECT_OK_I && AUX_REL_OK_I) [*7];
	endsequence
	sequence s_unpowered;
		(!BUS_LOCKOUT_OK_I && !AUX_DETECT_OK_I) [*7];
	endsequence
	sequence s_paused;
		((THERM_COLD_I || THERM_HOT_I) && !THERM_CRIT_I) [*7];
	endsequence
	AST_DIODE_ON: assert property (IDEAL_DIODE_EN_O)
		else $error("ideal diode disabled");
	AST_SDA_OPEN_DRAIN: assert property (!SDA_O)
		else $error("data line driven high");
	AST_SUSPEND_OFF: assert property (INPUT_LIMIT_SEL_O[2:1] == 2'h3 |-> !BUS_REG_EN_O)
		else $error("bus regulator on in suspend");
	AST_NO_BUS_OFF: assert property (!BUS_LOCKOUT_OK_I [*7] |-> !BUS_REG_EN_O)
		else $error("bus regulator on without bus supply");
	AST_AUX_PRIORITY: assert property (s_aux_held |-> !BUS_REG_EN_O)
		else $error("bus regulator on with aux power");
	AST_NO_POWER_IDLE: assert property (s_unpowered |-> !CHARGE_EN_O)
		else $error("charger runs without power");
	AST_THERM_PAUSE: assert property (s_paused |-> !CHARGE_EN_O)
		else $error("charger runs while too cold or hot");
	AST_DATA_CLK_LOW: assert property ($changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 3))
		else $error("data line moved while serial clock high");
	AST_IRQ_CLEAR_ACK: assert property ($fell(IRQ_PENDING_O) |-> SDA_OE_O)
		else $error("pending cleared outside address acknowledge");
	AST_RESET_VALUES: assert property ($rose(RST_N_I) |-> CX_SEL_O == 2'h0 && INPUT_LIMIT_SEL_O == 3'h0)
		else $error("control fields not at reset value");
endmodule // chs_status_checker
bind chs_status chs_status_checker chs_status_checker_inst (.CLK_I, .RST_N_I, .CE_I, .SCL_I,
	.BUS_LOCKOUT_OK_I, .AUX_DETECT_OK_I, .AUX_REL_OK_I, .THERM_COLD_I, .THERM_HOT_I, .THERM_CRIT_I,
	.SDA_O, .SDA_OE_O, .BUS_REG_EN_O, .CHARGE_EN_O, .IDEAL_DIODE_EN_O, .IRQ_PENDING_O, .INPUT_LIMIT_SEL_O,
	.CX_SEL_O);
`default_nettype wire

// File: bench/chs_host.sv
// Serial host model that commands and reads the charger block
`timescale 1ns/100ps
`default_nettype none
`include "chs_defines.svh"
module chs_host (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_o
);
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// Eight-cycle phases keep every level well past the synchroniser
	task automatic hold(input logic c, input logic d);
		@(posedge clk_i);
		scl_o <= c;
		sda_oe_o <= d;
		repeat (7) @(posedge clk_i);
	endtask
	// Data moves only mid low phase, never beside the clock edge
	task automatic bitx(input logic d, output logic s);
		hold(1'b0, sda_oe_o);
		hold(1'b0, !d);
		hold(1'b1, !d);
		s = sda_i;
	endtask
	task automatic xbyte(input logic [7:0] w, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			bitx(w[i], r[i]);
		end
	endtask
	task automatic open_frame(input logic rd);
		logic       a;
		logic [7:0] r;
		hold(1'b1, 1'b0);
		hold(1'b1, 1'b1);
		hold(1'b0, 1'b1);
		xbyte({`CHS_ADDR_DEFAULT, rd}, r);
		bitx(1'b1, a);
	endtask
	task automatic stop;
		hold(1'b0, sda_oe_o);
		hold(1'b0, 1'b1);
		hold(1'b1, 1'b1);
		hold(1'b1, 1'b0);
	endtask
	task automatic wr(input logic [7:0] sub, input logic [7:0] d);
		logic       a;
		logic [7:0] r;
		open_frame(1'b0);
		xbyte(sub, r);
		bitx(1'b1, a);
		xbyte(d, r);
		bitx(1'b1, a);
		stop;
	endtask
	// Released data line reads high through the pull-up
	task automatic rd(output logic [7:0] s);
		logic a;
		open_frame(1'b1);
		xbyte(8'hFF, s);
		bitx(1'b1, a);
		stop;
	endtask
endmodule // chs_host
`default_nettype wire

// File: bench/tb_chs_status.sv
// Self-checking bench for the charger status block
`timescale 1ns/100ps
`default_nettype none
module tb_chs_status;
	// {bus abs, bus rel, aux abs, aux rel, precharge, treg, cold, hot, crit, float, below cx, ilim, done}
	localparam logic [12:0] BUS = 13'h1800;
	localparam logic [12:0] AUX = 13'h0600;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ce = 1'b1;
	logic [12:0] pin = 13'h0000;
	logic        scl, host_oe, sda_oe, breg, chg, diode, irq, fh, tl;
	logic [2:0]  lsel;
	logic [1:0]  cxs;
	logic [7:0]  s;
	int          fails = 0;
	int          compares = 0;
	int          cyc = 0;
	logic [3:0]  cv [4] = '{4'h0, 4'h8, 4'hC, 4'hE};
	logic [1:0]  cc [4] = '{2'h1, 2'h2, 2'h3, 2'h2};
	logic [12:0] tv [3] = '{13'h0040, 13'h0020, 13'h0010};
	logic [8:0]  te [3] = '{9'h084, 9'h088, 9'h18D};
	wire logic   sda = !(host_oe || sda_oe);
	always #4 clk = !clk;
	chs_status #(.BAD_CELL_CYCLES(38'h14)) chs_status_inst (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
		.SCL_I(scl), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe), .BUS_LOCKOUT_OK_I(pin[12]),
		.BUS_REL_LOCKOUT_OK_I(pin[11]), .AUX_DETECT_OK_I(pin[10]), .AUX_REL_OK_I(pin[9]),
		.PRECHARGE_LOW_I(pin[8]), .THERMAL_REG_I(pin[7]), .THERM_COLD_I(pin[6]), .THERM_HOT_I(pin[5]),
		.THERM_CRIT_I(pin[4]), .FLOAT_REACHED_I(pin[3]), .BELOW_CX_I(pin[2]), .INPUT_LIMIT_I(pin[1]),
		.CYCLE_DONE_I(pin[0]), .BUS_REG_EN_O(breg), .CHARGE_EN_O(chg), .IDEAL_DIODE_EN_O(diode),
		.INPUT_LIMIT_SEL_O(lsel), .CX_SEL_O(cxs), .FLOAT_HIGH_O(fh), .TREG_LOW_O(tl), .IRQ_PENDING_O(irq));
	chs_host chs_host_inst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rs(input logic [7:0] exp);
		logic [7:0] v;
		chs_host_inst.rd(v);
		chk({8'h00, v}, {8'h00, exp});
	endtask
	task automatic put(input logic [12:0] v);
		@(posedge clk);
		pin <= v;
		repeat (8) @(posedge clk);
	endtask
	task automatic final_report;
		if (fails == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Ceiling well above the roughly 18k cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			final_report;
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk({12'h0, diode, breg, chg, irq}, 16'h0008);
		chk({11'h0, lsel, cxs}, 16'h0000);
		rs(8'h00);
		put(13'h1000);
		chk({15'h0, breg}, 16'h0000);
		put(BUS);
		chk({14'h0, breg, chg}, 16'h0003);
		rs(8'h81);
		for (int i = 6; i < 8; i++) begin
			chs_host_inst.wr(8'h00, {3'(i), 3'h0, 2'(i)});
			chk({10'h0, lsel, cxs, breg}, {10'h0, 3'(i), 2'(i), 1'b0});
		end
		chs_host_inst.wr(8'h00, 8'h00);
		chk({15'h0, breg}, 16'h0001);
		put(BUS | 13'h0400);
		rs(8'h81);
		put(BUS | AUX);
		chk({15'h0, breg}, 16'h0000);
		rs(8'hC1);
		for (int i = 0; i < 4; i++) begin
			put(BUS | {9'h000, cv[i]});
			rs({6'h20, cc[i]});
		end
		for (int i = 0; i < 3; i++) begin
			put(BUS | tv[i]);
			chs_host_inst.rd(s);
			chk({7'h0, chg, s}, {7'h0, te[i]});
		end
		put(BUS);
		chk({15'h0, chg}, 16'h0001);
		chk({15'h0, irq}, 16'h0000);
		chs_host_inst.wr(8'h02, 8'h10);
		put(BUS | 13'h0080);
		chk({15'h0, irq}, 16'h0001);
		put(BUS | 13'h00C0);
		rs(8'h91);
		chk({15'h0, irq}, 16'h0000);
		rs(8'h94);
		put(BUS);
		rs(8'h81);
		chs_host_inst.wr(8'h02, 8'h00);
		chs_host_inst.wr(8'h03, 8'hFF);
		rs(8'h81);
		chk({9'h0, lsel, cxs, fh, tl}, 16'h0000);
		chs_host_inst.wr(8'h01, 8'h16);
		chk({13'h0, chg, fh, tl}, 16'h0003);
		rs(8'h80);
		chs_host_inst.wr(8'h01, 8'h00);
		chk({15'h0, chg}, 16'h0001);
		put(BUS | 13'h0001);
		chk({15'h0, chg}, 16'h0000);
		put(BUS);
		chk({15'h0, chg}, 16'h0000);
		chs_host_inst.wr(8'h01, 8'h10);
		chs_host_inst.wr(8'h01, 8'h00);
		put(BUS | 13'h0100);
		rs(8'hA1);
		put(BUS);
		chs_host_inst.wr(8'h01, 8'h10);
		chs_host_inst.wr(8'h01, 8'h00);
		rs(8'h81);
		// Clock enable low freezes the synchronisers, so outputs hold
		@(posedge clk);
		ce <= 1'b0;
		put(13'h0000);
		chk({14'h0, breg, chg}, 16'h0003);
		@(posedge clk);
		ce <= 1'b1;
		put(13'h0000);
		chk({14'h0, breg, chg}, 16'h0000);
		rs(8'h00);
		final_report;
	end
endmodule // tb_chs_status
`default_nettype wire
